// ---- pkg/asf_defs.svh ----
// named offsets, field positions, reset values and codes of the axis status block
// assumes inclusion by bare name from the design files
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define ASF_OFS_STATUS     8'h00
`define ASF_OFS_ERRCAUSE   8'h04
`define ASF_OFS_CONFIG     8'h08
`define ASF_OFS_IRQSTAT    8'h0C
`define ASF_OFS_IRQMASK    8'h10
`define ASF_OFS_CMP3DATA   8'h14
`define ASF_OFS_MOTIONDATA 8'h18
// ****************************************************************
// field positions
// ****************************************************************
`define ASF_ST_CLEAR       17
`define ASF_ST_LATCH       18
`define ASF_ST_POSDONE     19
`define ASF_ST_CMP_LO      20
`define ASF_ST_PULSE       23
`define ASF_ST_PHASE_LO    24
`define ASF_ST_CMP3OCC_LO  28
`define ASF_ST_MOTIONOCC_LO 30
`define ASF_CFG_RCD        0
`define ASF_IRQ_ERR        0
`define ASF_IRQ_REFUSE     1
// ****************************************************************
// masks, reset values, codes
// ****************************************************************
`define ASF_ERR_VALID      32'h007F_F7FF
`define ASF_WORD_ZERO      32'h0000_0000
`define ASF_WORD_ONES      32'hFFFF_FFFF
`define ASF_CFG_RESET      1'h0
`define ASF_IRQ_RESET      2'h0
`define ASF_RESP_OKAY      2'h0
`define ASF_RESP_SLVERR    2'h2
`define ASF_CNT_EMPTY      2'h0
`define ASF_CNT_ONE        2'h1
`define ASF_CNT_FULL       2'h2
`define ASF_OCC_NONE       2'h0
`define ASF_OCC_ONE        2'h1
`define ASF_OCC_BOTH       2'h2
`define ASF_PIN_RESET      7'h00
`endif

// ---- pkg/asf_pkg.sv ----
// types shared by the axis status block
// assumes the constants header is included by its users
package asf_pkg;
  typedef logic [31:0] asf_word_t;
  typedef logic [1:0]  asf_occ_t;
  typedef logic [1:0]  asf_cnt_t;
endpackage : asf_pkg

// ---- design/asf_axis_status.sv ----
// axis status word, error cause flags, preload pairs and interrupt behind AXI4-Lite
// assumes one clock mclk, synchronous reset srst, input polarity already resolved
//
// Behaviour
// - status bits 17-19 show clear, latch and positioning-done inputs while active
// - status bits 20-22 show comparators one to three met
// - status bit 23 shows the pulse output active
// - status bits 24-27 show phase lines one to four at high level
// - bits 29:28 give comparator three pair occupancy as 00, 01, 1X
// - bits 31:30 give operation pair occupancy with the same encoding
// - a pair holding two entries refuses any further write
// - an error event sets its cause bit, held until cleared
// - with read-clear-disable low, a cause register read clears every bit
// - a cause register write clears only the bits written as one
// - with read-clear-disable high reads keep flags; writing back clears them
// - retried reads see cleared contents; hosts should set read-clear-disable
// - cause bits 0-10 stop causes, bit 11 zero, bits 12-15 errors
// - cause bits 16-22 errors; bits 23-31 read zero, writes ignored
// - the status word is read only; writes change nothing
// - cause bits 0-10 ordered comparators, limits, alarm, stops, overflow, watchdog
`timescale 1ns/1ps
`include "asf_defs.svh"
module asf_axis_status (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        clearInput,
  input  wire logic        latchInput,
  input  wire logic        positionDoneInput,
  input  wire logic [3:0]  phaseLine,
  input  wire logic [2:0]  comparatorMet,
  input  wire logic        pulseOutputActive,
  input  wire logic [22:0] errorEvent,
  input  wire logic        cmp3Consume,
  input  wire logic        motionConsume,
  output logic [31:0]      cmp3Value,
  output logic [31:0]      motionValue,
  output logic             irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic asf_pkg::asf_word_t strbMask(input logic [3:0] strb);
    asf_pkg::asf_word_t m;
    m = `ASF_WORD_ZERO;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction : strbMask

  function automatic asf_pkg::asf_occ_t occCode(input asf_pkg::asf_cnt_t cnt);
    asf_pkg::asf_occ_t o;
    o = `ASF_OCC_NONE;
    case (cnt)
      `ASF_CNT_EMPTY: o = `ASF_OCC_NONE;
      `ASF_CNT_ONE:   o = `ASF_OCC_ONE;
      default:        o = `ASF_OCC_BOTH;
    endcase
    return o;
  endfunction : occCode

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [6:0] pinRaw;
  logic [6:0] pinS1_reg;
  logic [6:0] pinS2_reg;
  logic [6:0] pinS3_reg;
  logic [6:0] pinStable_reg;

  assign pinRaw = {phaseLine, positionDoneInput, latchInput, clearInput};

  // a change counts only once the last two stages agree, filtering one-cycle glitches
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinS1_reg     <= `ASF_PIN_RESET;
      pinS2_reg     <= `ASF_PIN_RESET;
      pinS3_reg     <= `ASF_PIN_RESET;
      pinStable_reg <= `ASF_PIN_RESET;
    end else begin
      pinS1_reg     <= pinRaw;
      pinS2_reg     <= pinS1_reg;
      pinS3_reg     <= pinS2_reg;
      pinStable_reg <= (pinS2_reg & pinS3_reg) |
                       (pinStable_reg & (pinS2_reg | pinS3_reg));
    end
  end

  // ****************************************************************
  // AXI4-Lite write channels
  // ****************************************************************
  logic        awHeld_reg;
  logic [7:0]  awAddr_reg;
  logic        wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        doWrite;

  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      awHeld_reg    <= 1'b0;
      awAddr_reg    <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awHeld_reg    <= 1'b1;
      awAddr_reg    <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg    <= 1'b0;
    end else if (!awHeld_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_wready <= 1'b0;
      wHeld_reg    <= 1'b0;
      wData_reg    <= `ASF_WORD_ZERO;
      wStrb_reg    <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wHeld_reg    <= 1'b1;
      wData_reg    <= s_axi_wdata;
      wStrb_reg    <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_reg    <= 1'b0;
    end else if (!wHeld_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  asf_pkg::asf_cnt_t pairCount_reg [2];
  asf_pkg::asf_word_t pairMain_reg [2];
  asf_pkg::asf_word_t pairPre_reg [2];
  logic [1:0]  pairHit;
  logic [1:0]  pairWrite;
  logic [1:0]  pairConsume;
  logic        writeRefused;
  logic        writeMapped;
  asf_pkg::asf_word_t wMask;

  assign wMask       = strbMask(wStrb_reg);
  assign pairConsume = {motionConsume, cmp3Consume};
  assign pairHit[0]  = doWrite && (awAddr_reg == `ASF_OFS_CMP3DATA);
  assign pairHit[1]  = doWrite && (awAddr_reg == `ASF_OFS_MOTIONDATA);
  assign pairWrite[0] = pairHit[0] && (pairCount_reg[0] != `ASF_CNT_FULL);
  assign pairWrite[1] = pairHit[1] && (pairCount_reg[1] != `ASF_CNT_FULL);
  assign writeRefused = (pairHit[0] && !pairWrite[0]) || (pairHit[1] && !pairWrite[1]);
  // the status word accepts writes silently and keeps no state of them
  assign writeMapped = (awAddr_reg == `ASF_OFS_STATUS) ||
                       (awAddr_reg == `ASF_OFS_ERRCAUSE) ||
                       (awAddr_reg == `ASF_OFS_CONFIG) ||
                       (awAddr_reg == `ASF_OFS_IRQSTAT) ||
                       (awAddr_reg == `ASF_OFS_IRQMASK) ||
                       (awAddr_reg == `ASF_OFS_CMP3DATA) ||
                       (awAddr_reg == `ASF_OFS_MOTIONDATA);

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ASF_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (writeMapped && !writeRefused) ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // preload pairs: index 0 comparator three, index 1 operation
  // ****************************************************************
  // a consume and a write in one cycle leave one entry: the new word moves straight in
  always_ff @(posedge mclk) begin
    for (int p = 0; p < 2; p++) begin
      if (srst) begin
        pairCount_reg[p] <= `ASF_CNT_EMPTY;
        pairMain_reg[p]  <= `ASF_WORD_ZERO;
        pairPre_reg[p]   <= `ASF_WORD_ZERO;
      end else begin
        case (pairCount_reg[p])
          `ASF_CNT_EMPTY: begin
            if (pairWrite[p]) begin
              pairMain_reg[p]  <= wData_reg;
              pairCount_reg[p] <= `ASF_CNT_ONE;
            end
          end
          `ASF_CNT_ONE: begin
            if (pairWrite[p] && pairConsume[p]) begin
              pairMain_reg[p]  <= wData_reg;
            end else if (pairConsume[p]) begin
              pairCount_reg[p] <= `ASF_CNT_EMPTY;
            end else if (pairWrite[p]) begin
              pairPre_reg[p]   <= wData_reg;
              pairCount_reg[p] <= `ASF_CNT_FULL;
            end
          end
          default: begin
            if (pairConsume[p]) begin
              pairMain_reg[p]  <= pairPre_reg[p];
              pairCount_reg[p] <= `ASF_CNT_ONE;
            end
          end
        endcase
      end
    end
  end

  assign cmp3Value   = pairMain_reg[0];
  assign motionValue = pairMain_reg[1];

  // ****************************************************************
  // configuration and interrupt mask
  // ****************************************************************
  logic       readClearDisable_reg;
  logic [1:0] irqMask_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      readClearDisable_reg <= `ASF_CFG_RESET;
    end else if (doWrite && (awAddr_reg == `ASF_OFS_CONFIG) && wStrb_reg[0]) begin
      readClearDisable_reg <= wData_reg[`ASF_CFG_RCD];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irqMask_reg <= `ASF_IRQ_RESET;
    end else if (doWrite && (awAddr_reg == `ASF_OFS_IRQMASK) && wStrb_reg[0]) begin
      irqMask_reg <= wData_reg[1:0];
    end
  end

  // ****************************************************************
  // error cause flags
  // ****************************************************************
  asf_pkg::asf_word_t errCause_reg;
  asf_pkg::asf_word_t errSet;
  asf_pkg::asf_word_t errClr;
  logic        arTaken;
  logic        readClear;
  logic        writeErr;

  assign arTaken   = s_axi_arvalid && s_axi_arready;
  // the clear lands on the read's own edge, so a retried read already sees zero
  assign readClear = arTaken && (s_axi_araddr == `ASF_OFS_ERRCAUSE) &&
                     !readClearDisable_reg;
  assign writeErr  = doWrite && (awAddr_reg == `ASF_OFS_ERRCAUSE);
  // bit order of errorEvent follows the cause register layout
  assign errSet    = {9'h000, errorEvent} & `ASF_ERR_VALID;
  assign errClr    = (readClear ? `ASF_WORD_ONES : `ASF_WORD_ZERO) |
                     (writeErr ? (wData_reg & wMask) : `ASF_WORD_ZERO);

  always_ff @(posedge mclk) begin
    if (srst) begin
      errCause_reg <= `ASF_WORD_ZERO;
    end else begin
      errCause_reg <= (errCause_reg & ~errClr) | errSet;
    end
  end

  // ****************************************************************
  // interrupt status and output
  // ****************************************************************
  logic [1:0] irqStatus_reg;
  logic [1:0] irqSet;
  logic [1:0] irqClr;

  assign irqSet[`ASF_IRQ_ERR]    = |errSet;
  assign irqSet[`ASF_IRQ_REFUSE] = writeRefused;
  assign irqClr = (doWrite && (awAddr_reg == `ASF_OFS_IRQSTAT) && wStrb_reg[0]) ?
                  wData_reg[1:0] : 2'h0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      irqStatus_reg <= `ASF_IRQ_RESET;
    end else begin
      irqStatus_reg <= (irqStatus_reg & ~irqClr) | irqSet;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irqStatus_reg & ~irqClr | irqSet) & irqMask_reg);
    end
  end

  // ****************************************************************
  // status word and read channel
  // ****************************************************************
  asf_pkg::asf_word_t statusWord;
  asf_pkg::asf_word_t readValue;
  logic        readMapped;

  // lower status bits belong to other logic and read zero here
  always_comb begin
    statusWord = `ASF_WORD_ZERO;
    statusWord[`ASF_ST_CLEAR]   = pinStable_reg[0];
    statusWord[`ASF_ST_LATCH]   = pinStable_reg[1];
    statusWord[`ASF_ST_POSDONE] = pinStable_reg[2];
    statusWord[`ASF_ST_CMP_LO +: 3]   = comparatorMet;
    statusWord[`ASF_ST_PULSE]         = pulseOutputActive;
    statusWord[`ASF_ST_PHASE_LO +: 4] = pinStable_reg[6:3];
    statusWord[`ASF_ST_CMP3OCC_LO +: 2]   = occCode(pairCount_reg[0]);
    statusWord[`ASF_ST_MOTIONOCC_LO +: 2] = occCode(pairCount_reg[1]);
  end

  always_comb begin
    readValue  = `ASF_WORD_ZERO;
    readMapped = 1'b1;
    case (s_axi_araddr)
      `ASF_OFS_STATUS:     readValue = statusWord;
      `ASF_OFS_ERRCAUSE:   readValue = errCause_reg;
      `ASF_OFS_CONFIG:     readValue = {31'h0000_0000, readClearDisable_reg};
      `ASF_OFS_IRQSTAT:    readValue = {30'h0000_0000, irqStatus_reg};
      `ASF_OFS_IRQMASK:    readValue = {30'h0000_0000, irqMask_reg};
      `ASF_OFS_CMP3DATA:   readValue = pairMain_reg[0];
      `ASF_OFS_MOTIONDATA: readValue = pairMain_reg[1];
      default:             readMapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `ASF_WORD_ZERO;
      s_axi_rresp   <= `ASF_RESP_OKAY;
    end else if (arTaken) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readValue;
      s_axi_rresp   <= readMapped ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking asfClk @(posedge mclk); endclocking
  default disable iff (srst);

  pin_filter_a: assert property ((pinS2_reg == pinS3_reg) |=>
    (pinStable_reg == $past(pinS2_reg)))
    else $error("filtered pin level does not follow agreeing stages");
  cmp_read_a: assert property ((arTaken && s_axi_araddr == `ASF_OFS_STATUS) |=>
    (s_axi_rdata[22:20] == $past(comparatorMet) && s_axi_rdata[23] == $past(pulseOutputActive)))
    else $error("status read misreports comparator or pulse bits");
  occ_code_a: assert property ((statusWord[29:28] != 2'h3) &&
    (statusWord[31:30] != 2'h3) && ((pairCount_reg[0] == 2'h2) == statusWord[29]))
    else $error("occupancy field encoding wrong");
  pair_refuse_a: assert property ((pairHit[0] && pairCount_reg[0] == 2'h2 && !cmp3Consume) |=>
    (pairPre_reg[0] == $past(pairPre_reg[0]) && s_axi_bresp == 2'h2 && s_axi_bvalid))
    else $error("full pair accepted a write");
  err_sticky_a: assert property ((errSet != 32'h0) |=>
    ((errCause_reg & $past(errSet)) == $past(errSet)))
    else $error("error event lost");
  read_clear_a: assert property ((readClear && errorEvent == 23'h0) |=>
    (errCause_reg == 32'h0))
    else $error("read did not clear cause flags");
  write_clear_a: assert property ((writeErr && !readClear && errorEvent == 23'h0) |=>
    (errCause_reg == ($past(errCause_reg) & ~($past(wData_reg) & $past(wMask)))))
    else $error("write clear touched wrong bits");
  no_read_clear_a: assert property ((arTaken && readClearDisable_reg && !writeErr) |=>
    ((errCause_reg & $past(errCause_reg)) == $past(errCause_reg)))
    else $error("read cleared flags while disabled");
  err_reserved_a: assert property ((errCause_reg & 32'hFF80_0800) == 32'h0)
    else $error("reserved cause bit set");
  write_resp_a: assert property (doWrite |=> s_axi_bvalid ##1 (!s_axi_bvalid || s_axi_awready == 1'b0))
    else $error("write response missing");

  read_clear_c: cover property (readClear ##1 errCause_reg == 32'h0);
  refuse_c: cover property (pairHit[1] && pairCount_reg[1] == 2'h2);
  irq_rise_c: cover property ($rose(irq));
  pair_full_c: cover property (statusWord[29] ##[1:20] statusWord[29:28] == 2'h1);

endmodule : asf_axis_status

// ---- dv/asf_host_model.sv ----
// host side model: an AXI4-Lite master issuing one register access at a time
// assumes one clock; the bench calls wr and rd only after reset has been released
`timescale 1ns/1ps
module asf_host_model (
  input  wire logic        mclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'h0;
    s_axi_wdata   = 32'h0000_0000;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'h0;
    s_axi_bready  = 1'h0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'h0;
    s_axi_rready  = 1'h0;
  end
  // no wait is bounded here: a hung slave is cut short by the bench watchdog
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    forever begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bready && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    forever begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rready && s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask : rd
endmodule : asf_host_model

// ---- dv/test_axis_status_and_error_flags.sv ----
// self-checking bench for the axis status block, host model on the register bus
// assumes the design and host model files are compiled first
`timescale 1ns/1ps
`include "asf_defs.svh"
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_axis_status_and_error_flags;
  logic mclk, srst, clearInput, latchInput, positionDoneInput, pulseOutputActive;
  logic cmp3Consume, motionConsume, irq;
  logic [3:0] phaseLine;
  logic [2:0] comparatorMet;
  logic [22:0] errorEvent;
  logic [31:0] cmp3Value, motionValue, s_axi_wdata, s_axi_rdata;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures = 0;
  int nChecks = 0;
  asf_axis_status i_asf_axis_status (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clearInput, .latchInput, .positionDoneInput,
    .phaseLine, .comparatorMet, .pulseOutputActive, .errorEvent, .cmp3Consume, .motionConsume,
    .cmp3Value, .motionValue, .irq);
  asf_host_model i_asf_host_model (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    i_asf_host_model.rd(a, d, r);
    `CHK(nm, e, d)
    `CHK({nm, " resp"}, er, r)
  endtask : rd_chk
  task automatic wr_chk(input string nm, input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic [1:0] r;
    i_asf_host_model.wr(a, d, r);
    `CHK(nm, er, r)
  endtask : wr_chk
  task automatic pins(input logic [2:0] ctl, input logic [2:0] cm, input logic p,
                      input logic [3:0] ph);
    clearInput        <= ctl[0];
    latchInput        <= ctl[1];
    positionDoneInput <= ctl[2];
    comparatorMet     <= cm;
    pulseOutputActive <= p;
    phaseLine         <= ph;
    repeat (8) @(posedge mclk);
  endtask : pins
  task automatic pulse_err(input logic [22:0] ev);
    errorEvent <= ev;
    @(posedge mclk);
    errorEvent <= 23'h000000;
    repeat (2) @(posedge mclk);
  endtask : pulse_err
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk("status rst", `ASF_OFS_STATUS, 32'h0000_0000, `ASF_RESP_OKAY);
    rd_chk("config rst", `ASF_OFS_CONFIG, 32'h0000_0000, `ASF_RESP_OKAY);
    rd_chk("cause rst", `ASF_OFS_ERRCAUSE, 32'h0000_0000, `ASF_RESP_OKAY);
    rd_chk("unmapped", 8'h40, 32'h0000_0000, `ASF_RESP_SLVERR);
  endtask : t_reset
  task automatic t_pins();
    pins(3'h7, 3'h5, 1'h1, 4'hA);
    rd_chk("status a", `ASF_OFS_STATUS, 32'h0ADE_0000, `ASF_RESP_OKAY);
    pins(3'h0, 3'h2, 1'h0, 4'h5);
    rd_chk("status b", `ASF_OFS_STATUS, 32'h0520_0000, `ASF_RESP_OKAY);
    wr_chk("status wr", `ASF_OFS_STATUS, 32'hFFFF_FFFF, `ASF_RESP_OKAY);
    rd_chk("status kept", `ASF_OFS_STATUS, 32'h0520_0000, `ASF_RESP_OKAY);
    pins(3'h0, 3'h0, 1'h0, 4'h0);
  endtask : t_pins
  task automatic t_read_clear();
    pulse_err(23'h7F_FFFF);
    `CHK("irq masked", 1'h0, irq)
    wr_chk("mask", `ASF_OFS_IRQMASK, 32'h0000_0003, `ASF_RESP_OKAY);
    repeat (3) @(posedge mclk);
    `CHK("irq on", 1'h1, irq)
    rd_chk("cause all", `ASF_OFS_ERRCAUSE, 32'h007F_F7FF, `ASF_RESP_OKAY);
    fork
      rd_chk("cause auto", `ASF_OFS_ERRCAUSE, 32'h0000_0000, `ASF_RESP_OKAY);
      begin
        // event on the read-clear edge itself: the set must survive
        @(posedge mclk);
        errorEvent <= 23'h00_0004;
        @(posedge mclk);
        errorEvent <= 23'h00_0000;
      end
    join
    rd_chk("cause rc race", `ASF_OFS_ERRCAUSE, 32'h0000_0004, `ASF_RESP_OKAY);
    wr_chk("irq clr", `ASF_OFS_IRQSTAT, 32'h0000_0003, `ASF_RESP_OKAY);
    repeat (3) @(posedge mclk);
    `CHK("irq off", 1'h0, irq)
  endtask : t_read_clear
  task automatic t_write_clear();
    wr_chk("rcd on", `ASF_OFS_CONFIG, 32'h0000_0001, `ASF_RESP_OKAY);
    pulse_err(23'h00_0403);
    rd_chk("cause 1", `ASF_OFS_ERRCAUSE, 32'h0000_0403, `ASF_RESP_OKAY);
    rd_chk("cause 2", `ASF_OFS_ERRCAUSE, 32'h0000_0403, `ASF_RESP_OKAY);
    wr_chk("hi wr", `ASF_OFS_ERRCAUSE, 32'hFF80_0000, `ASF_RESP_OKAY);
    rd_chk("cause hi", `ASF_OFS_ERRCAUSE, 32'h0000_0403, `ASF_RESP_OKAY);
    wr_chk("w1c", `ASF_OFS_ERRCAUSE, 32'h0000_0001, `ASF_RESP_OKAY);
    rd_chk("cause w1c", `ASF_OFS_ERRCAUSE, 32'h0000_0402, `ASF_RESP_OKAY);
    fork
      wr_chk("wb busy", `ASF_OFS_ERRCAUSE, 32'h0000_0402, `ASF_RESP_OKAY);
      begin
        // one-cycle event on the edge that performs the write clear
        do @(posedge mclk); while (!(s_axi_wvalid && s_axi_wready));
        errorEvent <= 23'h00_0002;
        @(posedge mclk);
        errorEvent <= 23'h00_0000;
      end
    join
    rd_chk("cause race", `ASF_OFS_ERRCAUSE, 32'h0000_0002, `ASF_RESP_OKAY);
    wr_chk("wb", `ASF_OFS_ERRCAUSE, 32'h0000_0002, `ASF_RESP_OKAY);
    rd_chk("cause none", `ASF_OFS_ERRCAUSE, 32'h0000_0000, `ASF_RESP_OKAY);
    wr_chk("irq clr2", `ASF_OFS_IRQSTAT, 32'h0000_0003, `ASF_RESP_OKAY);
  endtask : t_write_clear
  // one pair: fill until refused, then drain; sel picks the operation pair
  task automatic t_pair(input logic [7:0] ofs, input int lo, input logic sel);
    wr_chk("pair a", ofs, 32'hA5A5_0001, `ASF_RESP_OKAY);
    rd_chk("occ one", `ASF_OFS_STATUS, 32'h1 << lo, `ASF_RESP_OKAY);
    wr_chk("pair b", ofs, 32'hA5A5_0002, `ASF_RESP_OKAY);
    rd_chk("occ both", `ASF_OFS_STATUS, 32'h2 << lo, `ASF_RESP_OKAY);
    wr_chk("pair c", ofs, 32'hA5A5_0003, `ASF_RESP_SLVERR);
    rd_chk("refuse irq", `ASF_OFS_IRQSTAT, 32'h0000_0002, `ASF_RESP_OKAY);
    `CHK("main a", 32'hA5A5_0001, sel ? motionValue : cmp3Value)
    cmp3Consume   <= !sel;
    motionConsume <= sel;
    @(posedge mclk);
    cmp3Consume   <= 1'h0;
    motionConsume <= 1'h0;
    @(posedge mclk);
    `CHK("main b", 32'hA5A5_0002, sel ? motionValue : cmp3Value)
    rd_chk("occ back", `ASF_OFS_STATUS, 32'h1 << lo, `ASF_RESP_OKAY);
    cmp3Consume   <= !sel;
    motionConsume <= sel;
    @(posedge mclk);
    cmp3Consume   <= 1'h0;
    motionConsume <= 1'h0;
    rd_chk("occ none", `ASF_OFS_STATUS, 32'h0000_0000, `ASF_RESP_OKAY);
    wr_chk("irq clr3", `ASF_OFS_IRQSTAT, 32'h0000_0003, `ASF_RESP_OKAY);
  endtask : t_pair
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // ****************************************************************
  // clock, reset, sequence, watchdog
  // ****************************************************************
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    srst = 1'h1;
    errorEvent = 23'h000000;
    cmp3Consume = 1'h0;
    motionConsume = 1'h0;
    pins(3'h0, 3'h0, 1'h0, 4'h0);
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    repeat (2) @(posedge mclk);
    t_reset();
    t_pins();
    t_read_clear();
    t_write_clear();
    t_pair(`ASF_OFS_CMP3DATA, `ASF_ST_CMP3OCC_LO, 1'h0);
    t_pair(`ASF_OFS_MOTIONDATA, `ASF_ST_MOTIONOCC_LO, 1'h1);
    wrap_up();
  end
  // whole run needs well under 2000 cycles; allow ten times that
  initial begin
    #160000;
    failures++;
    wrap_up();
  end
endmodule : test_axis_status_and_error_flags
